/* File: htr_consts.svh */
/*
 holds the offsets, field positions, reset values and timing counts
 of the tuner request handler; assumes inclusion by bare name
*/
`ifndef HTR_CONSTS_SVH
`define HTR_CONSTS_SVH

// ==========================================================
// message tags
`define HTR_TAG_OOB_REQ 24'h9F8406
`define HTR_TAG_OOB_CNF 24'h9F8407
`define HTR_TAG_IB_REQ 24'h9F8408
`define HTR_TAG_IB_CNF 24'h9F8409
`define HTR_CNF_LEN 8'h01

// ==========================================================
// status codes
`define HTR_ST_OK 8'h00
`define HTR_OOB_ABSENT 8'h01
`define HTR_OOB_BUSY 8'h02
`define HTR_OOB_BADPAR 8'h03
`define HTR_OOB_OTHER 8'h04
`define HTR_IB_BADFREQ 8'h01
`define HTR_IB_BADMOD 8'h02
`define HTR_IB_HWFAIL 8'h03
`define HTR_IB_BUSY 8'h04

// ==========================================================
// field values
`define HTR_TT_SOURCE 8'h00
`define HTR_TT_FREQ 8'h01
`define HTR_MOD_Q64 8'h00
`define HTR_MOD_Q256 8'h01
`define HTR_OOB_BASE_50K 12'h3E8
`define HTR_OOB_LEN 8'h03
`define HTR_IB_SRC_LEN 8'h03
`define HTR_IB_FRQ_LEN 8'h04

// ==========================================================
// timing
`define HTR_OOB_WAIT_MS 500
`define HTR_CLK_KHZ 25000

// ==========================================================
// registers and fields
`define HTR_REG_CTRL 8'h00
`define HTR_REG_IRQ_STAT 8'h04
`define HTR_REG_IRQ_MASK 8'h08
`define HTR_REG_LAST 8'h0C
`define HTR_CTRL_IB_FORCE 0
`define HTR_CTRL_OOB_OFF 1
`define HTR_IRQ_OOB_CNF 0
`define HTR_IRQ_IB_CNF 1
`define HTR_IRQ_OOB_TMO 2
`define HTR_IRQ_BAD_MSG 3
`define HTR_CTRL_RST 2'h0
`define HTR_MASK_RST 4'h0

`endif

/* File: htr_pkg.sv */
/*
 types of the tuner request handler; assumes htr_consts.svh beside it
*/
`default_nettype none
package htr_pkg;
   typedef enum logic [1:0] {HTR_R2048, HTR_R1544, HTR_R3088} htr_rate_t;
   typedef enum {S_TAG, S_LEN, S_BODY, S_EXEC, S_WAIT, S_SEND} htr_state_t;
   typedef struct packed {
      logic [11:0] freq_50khz;
      htr_rate_t rate;
      logic inverted;
   } htr_oob_cfg_t;
   typedef struct packed {
      logic by_source;
      logic no_source;
      logic [15:0] code;
      logic qam256;
   } htr_ib_cmd_t;
endpackage : htr_pkg
`default_nettype wire

/* File: htr_cnf_tx.sv */
/*
 sends one confirm message: three tag bytes, length, status;
 assumes the receiving logic takes one byte per clock
*/
`timescale 1ns/1ps
`default_nettype none
`include "htr_consts.svh"
module htr_cnf_tx (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // request
   input wire logic i_go,
   input wire logic [23:0] i_tag,
   input wire logic [7:0] i_status,
   // byte stream
   output logic o_valid,
   output logic [7:0] o_byte,
   output logic o_last,
   output logic o_busy
);
   logic [2:0] idx_q;
   logic [23:0] tag_q;
   logic [7:0] st_q;

   // ==========================================================
   // sequencing
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         idx_q <= 3'h0;
         tag_q <= 24'h0;
         st_q <= 8'h0;
         o_busy <= 1'b0;
      end else if (i_go && !o_busy) begin
         idx_q <= 3'h0;
         tag_q <= i_tag;
         st_q <= i_status;
         o_busy <= 1'b1;
      end else if (o_busy) begin
         idx_q <= idx_q + 3'h1;
         if (idx_q == 3'h4) begin
            o_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_valid <= 1'b0;
         o_byte <= 8'h0;
         o_last <= 1'b0;
      end else begin
         o_valid <= o_busy;
         o_last <= o_busy && idx_q == 3'h4;
         case (idx_q)
            3'h0: o_byte <= tag_q[23:16];
            3'h1: o_byte <= tag_q[15:8];
            3'h2: o_byte <= tag_q[7:0];
            3'h3: o_byte <= `HTR_CNF_LEN;
            default: o_byte <= st_q;
         endcase
      end
   end
endmodule : htr_cnf_tx
`default_nettype wire

/* File: htr_handler.sv */
/*
 tuner request handler: parses receiver and in-band tune requests
 from the security module and answers each with one confirm;
 assumes message bytes, tuner status and policy inputs all come
 from logic on i_clk_sys
*/
// Functional notes
// (RULE1) module requests receiver setup by message
// (RULE2) one confirm for every receiver request
// (RULE3) confirm after acquisition or 500 ms
// (RULE4) receiver frequency is code*0.05 plus 50
// (RULE5) frequency sent MS first, top bits zero
// (RULE6) rate bits select 2048, 1544, 3088
// (RULE7) bit 0 selects spectrum inversion
// (RULE8) status zero means granted and configured
// (RULE9) denial codes absent, busy, params, other
// (RULE10) module requests in-band tuning by message
// (RULE11) tune type selects source or frequency
// (RULE12) source code zero means no source
// (RULE13) in-band frequency is code times 0.05
// (RULE14) modulation zero QAM-64, one QAM-256
// (RULE15) in-band confirm carries tag, length, status
// (RULE16) in-band codes accepted through tuner busy
// (RULE17) grant in-band only under homing policy; CTRL bit 0 lifts the policy check, not the hw fail, busy or field checks
// (RULE18) reserved codes answered with a rejection
`timescale 1ns/1ps
`default_nettype none
`include "htr_consts.svh"
module htr_handler #(
   parameter int unsigned P_WAIT_CYC = `HTR_OOB_WAIT_MS * `HTR_CLK_KHZ
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // request bytes from the security module
   input wire logic i_rx_valid,
   input wire logic i_rx_first,
   input wire logic [7:0] i_rx_byte,
   output logic o_rx_ready,
   // confirm bytes to the security module
   output logic o_tx_valid,
   output logic [7:0] o_tx_byte,
   output logic o_tx_last,
   // receiver tuner
   input wire logic i_oob_absent,
   input wire logic i_oob_busy,
   input wire logic i_oob_locked,
   output htr_pkg::htr_oob_cfg_t o_oob_cfg,
   output logic o_oob_start,
   // in-band tuner
   input wire logic i_ib_busy,
   input wire logic i_ib_hw_fail,
   input wire logic i_ib_freq_bad,
   output htr_pkg::htr_ib_cmd_t o_ib_cmd,
   output logic o_ib_start,
   // grant policy
   input wire logic i_homing_open,
   input wire logic i_standby,
   input wire logic i_fw_upgrade,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq
);
   import htr_pkg::*;

   htr_state_t state_q;
   logic [23:0] tag_q;
   logic [7:0] len_q;
   logic [7:0] cnt_q;
   logic [7:0] body_q [4];
   logic [23:0] wait_q;
   logic go_q;
   logic [23:0] ctag_q;
   logic [7:0] cst_q;
   logic tx_busy;
   logic tx_valid;
   logic [7:0] tx_byte;
   logic tx_last;
   logic [1:0] ctrl_q;
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   logic [3:0] ev;
   logic [7:0] last_oob_q;
   logic [7:0] last_ib_q;
   logic [7:0] oob_st;
   logic [7:0] ib_st;
   logic ib_allow;

   // ==========================================================
   // request checks
   always_comb begin
      oob_st = `HTR_ST_OK;
      if (i_oob_absent || ctrl_q[`HTR_CTRL_OOB_OFF]) begin
         oob_st = `HTR_OOB_ABSENT; // RULE9
      end else if (i_oob_busy) begin
         oob_st = `HTR_OOB_BUSY; // RULE9
      end else if (len_q != `HTR_OOB_LEN || body_q[0][7:3] != 5'h00
                   || body_q[2][5:1] != 5'h00) begin
         oob_st = `HTR_OOB_BADPAR; // RULE5 RULE7 RULE9
      end
   end

   // a tuner hardware failure is reported before policy so the module
   // learns of a broken tuner even while access is withheld
   assign ib_allow = ctrl_q[`HTR_CTRL_IB_FORCE]
      || (i_homing_open && (i_standby || i_fw_upgrade)); // RULE17

   always_comb begin
      ib_st = `HTR_ST_OK;
      if (i_ib_hw_fail) begin
         ib_st = `HTR_IB_HWFAIL; // RULE16
      end else if (!ib_allow || i_ib_busy) begin
         ib_st = `HTR_IB_BUSY; // RULE16 RULE17
      end else if (body_q[0] == `HTR_TT_SOURCE) begin
         if (len_q != `HTR_IB_SRC_LEN) begin
            ib_st = `HTR_IB_BADFREQ; // RULE18
         end
      end else if (body_q[0] == `HTR_TT_FREQ) begin
         if (len_q != `HTR_IB_FRQ_LEN || i_ib_freq_bad) begin
            ib_st = `HTR_IB_BADFREQ; // RULE16
         end else if (body_q[3] != `HTR_MOD_Q64
                      && body_q[3] != `HTR_MOD_Q256) begin
            ib_st = `HTR_IB_BADMOD; // RULE14 RULE18
         end
      end else begin
         ib_st = `HTR_IB_BADFREQ; // RULE11 RULE18
      end
   end

   // ==========================================================
   // message parser and sequencer
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= S_TAG;
         tag_q <= 24'h0;
         len_q <= 8'h0;
         cnt_q <= 8'h0;
         body_q <= '{default: 8'h0};
         wait_q <= 24'h0;
         go_q <= 1'b0;
         ctag_q <= 24'h0;
         cst_q <= 8'h0;
         o_rx_ready <= 1'b1;
         o_oob_start <= 1'b0;
         o_ib_start <= 1'b0;
      end else begin
         go_q <= 1'b0;
         o_oob_start <= 1'b0;
         o_ib_start <= 1'b0;
         case (state_q)
            S_TAG, S_LEN, S_BODY: begin
               if (i_rx_valid && (i_rx_first || state_q == S_TAG)) begin
                  tag_q <= {tag_q[15:0], i_rx_byte};
                  cnt_q <= i_rx_first ? 8'h1 : cnt_q + 8'h1;
                  if (!i_rx_first && cnt_q == 8'h2) begin
                     state_q <= S_LEN;
                  end else begin
                     state_q <= S_TAG;
                  end
               end else if (i_rx_valid && state_q == S_LEN) begin
                  // only the short length form fits these messages
                  len_q <= i_rx_byte;
                  cnt_q <= 8'h0;
                  if (i_rx_byte == 8'h00) begin
                     state_q <= S_EXEC;
                     o_rx_ready <= 1'b0;
                  end else begin
                     state_q <= S_BODY;
                  end
               end else if (i_rx_valid) begin
                  if (cnt_q < 8'h4) begin
                     body_q[cnt_q[1:0]] <= i_rx_byte; // RULE5 RULE13
                  end
                  cnt_q <= cnt_q + 8'h1;
                  if (cnt_q + 8'h1 == len_q) begin
                     state_q <= S_EXEC;
                     o_rx_ready <= 1'b0;
                  end
               end
            end
            S_EXEC: begin
               if (tag_q == `HTR_TAG_OOB_REQ) begin
                  ctag_q <= `HTR_TAG_OOB_CNF;
                  if (oob_st == `HTR_ST_OK) begin
                     o_oob_start <= 1'b1;
                     wait_q <= 24'h0;
                     state_q <= S_WAIT;
                  end else begin
                     cst_q <= oob_st; // RULE2 RULE9
                     go_q <= 1'b1;
                     state_q <= S_SEND;
                  end
               end else if (tag_q == `HTR_TAG_IB_REQ) begin
                  ctag_q <= `HTR_TAG_IB_CNF; // RULE15
                  cst_q <= ib_st; // RULE16 RULE18
                  o_ib_start <= ib_st == `HTR_ST_OK;
                  go_q <= 1'b1;
                  state_q <= S_SEND;
               end else begin
                  // unknown messages are dropped without an answer
                  state_q <= S_TAG;
                  cnt_q <= 8'h0;
                  o_rx_ready <= 1'b1;
               end
            end
            S_WAIT: begin
               if (i_oob_locked) begin
                  cst_q <= `HTR_ST_OK; // RULE3 RULE8
                  go_q <= 1'b1;
                  state_q <= S_SEND;
               end else if (wait_q == 24'(P_WAIT_CYC - 1)) begin
                  cst_q <= `HTR_OOB_OTHER; // RULE3 RULE9
                  go_q <= 1'b1;
                  state_q <= S_SEND;
               end else begin
                  wait_q <= wait_q + 24'h1;
               end
            end
            default: begin
               if (!go_q && !tx_busy) begin
                  state_q <= S_TAG;
                  cnt_q <= 8'h0;
                  o_rx_ready <= 1'b1;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // tuner settings
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_oob_cfg <= '0;
      end else if (state_q == S_EXEC && tag_q == `HTR_TAG_OOB_REQ
                   && oob_st == `HTR_ST_OK) begin
         o_oob_cfg.freq_50khz <= {1'b0, body_q[0][2:0], body_q[1]}
            + `HTR_OOB_BASE_50K; // RULE4
         case (body_q[2][7:6])
            2'b10: o_oob_cfg.rate <= HTR_R1544; // RULE6
            2'b11: o_oob_cfg.rate <= HTR_R3088; // RULE6
            default: o_oob_cfg.rate <= HTR_R2048; // RULE6
         endcase
         o_oob_cfg.inverted <= body_q[2][0]; // RULE7
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ib_cmd <= '0;
      end else if (state_q == S_EXEC && tag_q == `HTR_TAG_IB_REQ
                   && ib_st == `HTR_ST_OK) begin
         o_ib_cmd.by_source <= body_q[0] == `HTR_TT_SOURCE; // RULE11
         o_ib_cmd.code <= {body_q[1], body_q[2]}; // RULE12 RULE13
         o_ib_cmd.no_source <= body_q[0] == `HTR_TT_SOURCE
            && {body_q[1], body_q[2]} == 16'h0000; // RULE12
         o_ib_cmd.qam256 <= body_q[0] == `HTR_TT_FREQ
            && body_q[3] == `HTR_MOD_Q256; // RULE14
      end
   end

   // ==========================================================
   // confirm output
   htr_cnf_tx u_cnf_tx (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_go(go_q),
      .i_tag(ctag_q),
      .i_status(cst_q),
      .o_valid(tx_valid),
      .o_byte(tx_byte),
      .o_last(tx_last),
      .o_busy(tx_busy)
   );

   // registered again so every top output leaves a flop here
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tx_valid <= 1'b0;
         o_tx_byte <= 8'h0;
         o_tx_last <= 1'b0;
      end else begin
         o_tx_valid <= tx_valid;
         o_tx_byte <= tx_byte;
         o_tx_last <= tx_last;
      end
   end

   // ==========================================================
   // registers and interrupt
   always_comb begin
      ev = 4'h0;
      ev[`HTR_IRQ_OOB_CNF] = go_q && ctag_q == `HTR_TAG_OOB_CNF;
      ev[`HTR_IRQ_IB_CNF] = go_q && ctag_q == `HTR_TAG_IB_CNF;
      ev[`HTR_IRQ_OOB_TMO] = state_q == S_WAIT && !i_oob_locked
         && wait_q == 24'(P_WAIT_CYC - 1);
      ev[`HTR_IRQ_BAD_MSG] = state_q == S_EXEC
         && tag_q != `HTR_TAG_OOB_REQ && tag_q != `HTR_TAG_IB_REQ;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= `HTR_CTRL_RST;
         mask_q <= `HTR_MASK_RST;
      end else if (i_wr && i_addr == `HTR_REG_CTRL) begin
         ctrl_q <= i_wdata[1:0];
      end else if (i_wr && i_addr == `HTR_REG_IRQ_MASK) begin
         mask_q <= i_wdata[3:0];
      end
   end

   // a new event wins over a write-one clear in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_q <= 4'h0;
      end else if (i_wr && i_addr == `HTR_REG_IRQ_STAT) begin
         stat_q <= (stat_q & ~i_wdata[3:0]) | ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         last_oob_q <= 8'h0;
         last_ib_q <= 8'h0;
      end else if (ev[`HTR_IRQ_OOB_CNF]) begin
         last_oob_q <= cst_q;
      end else if (ev[`HTR_IRQ_IB_CNF]) begin
         last_ib_q <= cst_q;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 32'h0;
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(stat_q & mask_q);
         o_rdata <= 32'h0;
         if (i_rd && i_addr == `HTR_REG_CTRL) begin
            o_rdata <= {30'h0, ctrl_q};
         end else if (i_rd && i_addr == `HTR_REG_IRQ_STAT) begin
            o_rdata <= {28'h0, stat_q};
         end else if (i_rd && i_addr == `HTR_REG_IRQ_MASK) begin
            o_rdata <= {28'h0, mask_q};
         end else if (i_rd && i_addr == `HTR_REG_LAST) begin
            o_rdata <= {15'h0, !o_rx_ready, last_ib_q, last_oob_q};
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_oob_go;
      state_q == S_EXEC && tag_q == `HTR_TAG_OOB_REQ;
   endsequence
   sequence s_cnf_bytes;
      o_tx_valid && o_tx_byte == 8'h9F ##1 o_tx_valid ##1 o_tx_valid
         ##1 o_tx_byte == `HTR_CNF_LEN ##1 o_tx_last;
   endsequence

   property p_deny_cnf;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         s_oob_go and oob_st != `HTR_ST_OK |-> ##4 s_cnf_bytes;
   endproperty
   a_deny_cnf: assert property (p_deny_cnf) else $error("no confirm"); // RULE2

   property p_wait_max;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         wait_q < 24'(P_WAIT_CYC);
   endproperty
   a_wait_max: assert property (p_wait_max) else $error("wait overrun"); // RULE3

   property p_lock_ok;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         state_q == S_WAIT && i_oob_locked |=> go_q && cst_q == 8'h00
         ##3 s_cnf_bytes;
   endproperty
   a_lock_ok: assert property (p_lock_ok) else $error("lock not granted"); // RULE3 RULE8

   property p_freq;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         o_oob_start |-> o_oob_cfg.freq_50khz
            == {1'b0, body_q[0][2:0], body_q[1]} + 12'h3E8;
   endproperty
   a_freq: assert property (p_freq) else $error("bad rx freq"); // RULE4

   property p_rate;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         o_oob_start |-> (o_oob_cfg.rate == HTR_R1544) == (body_q[2][7:6] == 2'b10)
            && o_oob_cfg.inverted == body_q[2][0];
   endproperty
   a_rate: assert property (p_rate) else $error("bad rate"); // RULE6 RULE7

   property p_top_bits;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         s_oob_go and body_q[0][7:3] != 5'h00 |-> !o_oob_start [*4];
   endproperty
   a_top_bits: assert property (p_top_bits) else $error("bad code tuned"); // RULE5 RULE9

   property p_policy;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         state_q == S_EXEC && tag_q == `HTR_TAG_IB_REQ && !ib_allow
         |=> !o_ib_start && cst_q != 8'h00;
   endproperty
   a_policy: assert property (p_policy) else $error("ib granted"); // RULE17

   property p_bad_mod;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         state_q == S_EXEC && tag_q == `HTR_TAG_IB_REQ && ib_st == 8'h02
         |=> go_q && cst_q == 8'h02 && $stable(o_ib_cmd);
   endproperty
   a_bad_mod: assert property (p_bad_mod) else $error("bad mod acted"); // RULE14 RULE18

   property p_ib_cnf;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         state_q == S_EXEC && tag_q == `HTR_TAG_IB_REQ
         |=> ##3 s_cnf_bytes ##[1:4] o_rx_ready;
   endproperty
   a_ib_cnf: assert property (p_ib_cnf) else $error("no ib confirm"); // RULE15 RULE16

   property p_nosrc;
      @(posedge i_clk_sys) disable iff (!i_rstn)
         o_ib_start && o_ib_cmd.by_source |-> o_ib_cmd.no_source
            == (o_ib_cmd.code == 16'h0000);
   endproperty
   a_nosrc: assert property (p_nosrc) else $error("source flag"); // RULE12
endmodule : htr_handler
`default_nettype wire

/* File: htr_sec_model.sv */
/*
 security module model: sends request messages byte by byte and
 collects confirm bytes; assumes it shares the handler's clock
*/
`timescale 1ns/1ps
`default_nettype none
module htr_sec_model (
   // clock
   input wire logic i_clk_sys,
   // request link
   output logic o_rx_valid,
   output logic o_rx_first,
   output logic [7:0] o_rx_byte,
   input wire logic i_rx_ready,
   // confirm link
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_byte
);
   logic rdy_n = 1'b1;
   logic [7:0] cnf_q[$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_first = 1'b0;
      o_rx_byte = 8'h00;
   end
   // ==========================================================
   // sampling off the active edge keeps the handshake race free
   always @(negedge i_clk_sys) begin
      rdy_n <= i_rx_ready;
      if (i_tx_valid === 1'b1) cnf_q.push_back(i_tx_byte);
   end
   task automatic put(input logic [7:0] b, input logic f);
      o_rx_valid <= 1'b1;
      o_rx_first <= f;
      o_rx_byte <= b;
      do @(posedge i_clk_sys); while (rdy_n !== 1'b1);
   endtask : put
   // ==========================================================
   // tag and fields go most significant byte first
   task automatic send(input logic [23:0] tag, input int n, input logic [31:0] body);
      put(tag[23:16], 1'b1);
      put(tag[15:8], 1'b0);
      put(tag[7:0], 1'b0);
      put(8'(n), 1'b0);
      for (int i = n - 1; i >= 0; i--) put(body[8*i +: 8], 1'b0);
      o_rx_valid <= 1'b0;
      o_rx_byte <= ~o_rx_byte;
   endtask : send
endmodule : htr_sec_model
`default_nettype wire

/* File: htr_handler_tb_top.sv */
/*
 testbench of the tuner request handler; assumes htr_pkg,
 htr_consts.svh and the security module model beside it
*/
`timescale 1ns/1ps
`default_nettype none
`include "htr_consts.svh"
module htr_handler_tb_top;
   import htr_pkg::*;
   localparam int WAIT_CYC = 50;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic rx_valid, rx_first, rx_ready, tx_valid, tx_last, oob_start, ib_start, irq;
   logic [7:0] rx_byte, tx_byte;
   logic [7:0] addr = 8'h00;
   logic oob_absent = 0, oob_busy = 0, oob_locked = 0, ib_busy = 0, ib_hw_fail = 0, ib_freq_bad = 0;
   logic homing = 0, standby = 0, fw_up = 0, wr = 0, rd = 0;
   logic [31:0] wdata = 0, rdata;
   htr_oob_cfg_t oob_cfg;
   htr_ib_cmd_t ib_cmd;
   htr_rate_t rt[4] = '{HTR_R2048, HTR_R2048, HTR_R1544, HTR_R3088};
   int err_total = 0;
   int num_checks = 0;
   int n_oob = 0;
   int n_ib = 0;
   int n_last = 0;
   initial forever #20 i_clk_sys = ~i_clk_sys;
   // pulses stand one cycle, so they are counted mid-cycle
   always @(negedge i_clk_sys) begin
      n_oob += int'(oob_start === 1'b1);
      n_ib += int'(ib_start === 1'b1);
      n_last += int'(tx_last === 1'b1);
   end
   htr_handler #(.P_WAIT_CYC(WAIT_CYC)) htr_handler_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_rx_valid(rx_valid), .i_rx_first(rx_first), .i_rx_byte(rx_byte), .o_rx_ready(rx_ready),
      .o_tx_valid(tx_valid), .o_tx_byte(tx_byte), .o_tx_last(tx_last), .i_oob_absent(oob_absent),
      .i_oob_busy(oob_busy), .i_oob_locked(oob_locked), .o_oob_cfg(oob_cfg), .o_oob_start(oob_start),
      .i_ib_busy(ib_busy), .i_ib_hw_fail(ib_hw_fail), .i_ib_freq_bad(ib_freq_bad), .o_ib_cmd(ib_cmd),
      .o_ib_start(ib_start), .i_homing_open(homing), .i_standby(standby), .i_fw_upgrade(fw_up),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
   htr_sec_model htr_sec_model_inst (.i_clk_sys(i_clk_sys), .o_rx_valid(rx_valid), .o_rx_first(rx_first),
      .o_rx_byte(rx_byte), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte));
   // ==========================================================
   // checking and closing
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic final_report();
      if (err_total == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // message and register access
   task automatic cnf(input logic [23:0] tag, input logic [7:0] st, output int k);
      k = 0;
      while (htr_sec_model_inst.cnf_q.size() < 5 && k < 300) begin
         @(posedge i_clk_sys);
         k++;
      end
      repeat (10) @(posedge i_clk_sys);
      chk("cnf_count", 5, htr_sec_model_inst.cnf_q.size());
      chk("cnf_tag", tag, {htr_sec_model_inst.cnf_q[0], htr_sec_model_inst.cnf_q[1], htr_sec_model_inst.cnf_q[2]});
      chk("cnf_len", 8'h01, htr_sec_model_inst.cnf_q[3]);
      chk("cnf_status", st, htr_sec_model_inst.cnf_q[4]);
      htr_sec_model_inst.cnf_q.delete();
   endtask : cnf
   task automatic oob(input logic [15:0] f, input logic [7:0] r, input logic lk, ab, bz, input logic [7:0] st);
      int k;
      oob_locked <= lk;
      oob_absent <= ab;
      oob_busy <= bz;
      htr_sec_model_inst.send(`HTR_TAG_OOB_REQ, 3, {8'h00, f, r});
      cnf(`HTR_TAG_OOB_CNF, st, k);
      chk("oob_wait", lk, k < WAIT_CYC);
   endtask : oob
   task automatic ib(input int n, input logic [31:0] body, input logic [7:0] st, input logic [18:0] exp);
      int k;
      htr_sec_model_inst.send(`HTR_TAG_IB_REQ, n, body);
      cnf(`HTR_TAG_IB_CNF, st, k);
      if (st == 8'h00) chk("ib_cmd", exp, ib_cmd);
   endtask : ib
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk_sys);
      wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk_sys);
      rd <= 1'b0;
      @(negedge i_clk_sys);
      chk(what, exp, rdata);
      @(posedge i_clk_sys);
   endtask : reg_rd
   // ==========================================================
   // test sequence
   initial begin
      repeat (12) @(posedge i_clk_sys);
      chk("rst_ready", 1, rx_ready);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      oob(16'h0000, 8'h81, 1, 0, 0, 8'h00);
      chk("oob_cfg", {12'h3E8, HTR_R1544, 1'b1}, oob_cfg);
      for (int r = 0; r < 4; r++) begin
         oob(16'h07FF, 8'(r << 6), 1, 0, 0, 8'h00);
         chk("oob_cfg", {12'hBE7, rt[r], 1'b0}, oob_cfg);
      end
      oob(16'h0010, 8'h00, 0, 0, 0, 8'h04);
      oob(16'h0010, 8'h00, 1, 1, 1, 8'h01);
      oob(16'h0010, 8'h00, 1, 0, 1, 8'h02);
      oob(16'h0800, 8'h00, 1, 0, 0, 8'h03);
      oob(16'h0010, 8'h02, 1, 0, 0, 8'h03);
      ib(3, 32'h00001234, 8'h04, 0);
      homing <= 1;
      standby <= 1;
      ib(3, 32'h00001234, 8'h00, {2'b10, 16'h1234, 1'b0});
      ib(3, 32'h00000000, 8'h00, {2'b11, 16'h0000, 1'b0});
      ib(3, 32'h0000FFFF, 8'h00, {2'b10, 16'hFFFF, 1'b0});
      ib(4, 32'h01234501, 8'h00, {2'b00, 16'h2345, 1'b1});
      ib(4, 32'h01234500, 8'h00, {2'b00, 16'h2345, 1'b0});
      ib(4, 32'h01234502, 8'h02, 0);
      ib(3, 32'h00021234, 8'h01, 0);
      ib_freq_bad <= 1;
      ib(4, 32'h01234501, 8'h01, 0);
      ib_busy <= 1;
      ib(4, 32'h01234501, 8'h04, 0);
      ib_hw_fail <= 1;
      ib(4, 32'h01234501, 8'h03, 0);
      {ib_busy, ib_hw_fail, ib_freq_bad, standby, fw_up} <= 5'b00001;
      ib(4, 32'h01234501, 8'h00, {2'b00, 16'h2345, 1'b1});
      homing <= 0;
      ib(4, 32'h01234501, 8'h04, 0);
      reg_wr(`HTR_REG_CTRL, 32'h00000003);
      oob(16'h0010, 8'h00, 1, 0, 0, 8'h01);
      ib(4, 32'h01234501, 8'h00, {2'b00, 16'h2345, 1'b1});
      reg_rd(`HTR_REG_CTRL, 32'h00000003, "ctrl");
      htr_sec_model_inst.send(24'h9F8400, 1, 32'h0);
      repeat (20) @(posedge i_clk_sys);
      chk("drop_count", 0, htr_sec_model_inst.cnf_q.size());
      reg_rd(`HTR_REG_IRQ_STAT, 32'h0000000F, "irq_stat");
      chk("irq_masked", 0, irq);
      reg_wr(`HTR_REG_IRQ_MASK, 32'h00000004);
      repeat (3) @(negedge i_clk_sys);
      chk("irq_set", 1, irq);
      reg_wr(`HTR_REG_IRQ_STAT, 32'h00000004);
      repeat (3) @(negedge i_clk_sys);
      chk("irq_clear", 0, irq);
      @(posedge i_clk_sys);
      reg_rd(`HTR_REG_IRQ_STAT, 32'h0000000B, "irq_stat");
      reg_rd(`HTR_REG_IRQ_MASK, 32'h00000004, "irq_mask");
      reg_rd(`HTR_REG_LAST, 32'h00000001, "last");
      reg_rd(8'h10, 32'h00000000, "unmapped");
      chk("oob_starts", 6, n_oob);
      chk("ib_starts", 7, n_ib);
      chk("cnf_lasts", 25, n_last);
      final_report();
   end
   // a hang past 2 ms, many times the expected run length, ends the test
   initial begin
      #2000000;
      err_total++;
      final_report();
   end
endmodule : htr_handler_tb_top
`default_nettype wire
